// [core/srdsc_pkg.sv]
// Constants, register map and carrier types of the delayed-stop safety relay controller.
// Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
package srdsc_pkg;

	localparam int CLK_HZ   = 20_000_000;
	localparam int MS_PER_S = 1000;
	// Cycles in one millisecond; the top module takes this as an overridable parameter.
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

	localparam int ACT_DELAY_MS = 100;
	localparam int DISC_MS      = 50;
	localparam int TEST_MS      = 20;
	localparam logic [6:0] ACT_LAST  = 7'(ACT_DELAY_MS - 1);
	localparam logic [5:0] DISC_LAST = 6'(DISC_MS - 1);
	localparam logic [4:0] TEST_LAST = 5'(TEST_MS - 1);

	localparam int          ADDR_W    = 8;
	localparam logic [7:0]  ADDR_CTRL = 8'h00;
	localparam logic [7:0]  ADDR_DLY  = 8'h04;
	localparam logic [7:0]  ADDR_STAT = 8'h08;
	localparam logic [7:0]  ADDR_IRQS = 8'h0C;
	localparam logic [7:0]  ADDR_IRQM = 8'h10;

	localparam int CTRL_W        = 5;
	localparam int CTRL_DUAL     = 0;
	localparam int CTRL_STARTMON = 1;
	localparam int CTRL_ACTDLY   = 2;
	localparam int CTRL_NOLOCK   = 3;
	localparam int CTRL_GATELOCK = 4;
	localparam int CTRL_FCLR     = 5;
	localparam logic [CTRL_W-1:0] CTRL_RST  = 5'h03;
	localparam logic [15:0]       DELAY_RST = 16'h03E8;

	localparam int EV_W     = 5;
	localparam int EV_ACT   = 0;
	localparam int EV_STOP  = 1;
	localparam int EV_DLYOF = 2;
	localparam int EV_CHF   = 3;
	localparam int EV_STF   = 4;

	localparam int SB_IMM   = 0;
	localparam int SB_DLY   = 1;
	localparam int SB_LOCK  = 2;
	localparam int SB_CHF   = 3;
	localparam int SB_STF   = 4;
	localparam int SB_SAFE  = 5;
	localparam int SB_STATE = 8;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_ARMED,
		ST_RELOCK,
		ST_ACT_WAIT,
		ST_ON
	} srdsc_state_e;

	typedef struct packed {
		logic door1;
		logic door2;
		logic start;
		logic fb;
		logic auto_link;
		logic imm_rb;
		logic dly_rb;
	} srdsc_pins_s;

	typedef struct packed {
		srdsc_state_e      state;
		logic              imm;
		logic              dly;
		logic              lock;
		logic [15:0]       dly_cnt;
		logic [6:0]        act_cnt;
		logic [23:0]       ms_cnt;
		logic [5:0]        disc_cnt;
		logic [4:0]        test_cnt;
		logic              ch_fault;
		logic              st_fault;
		logic              start_q;
		logic              start_open;
		logic [CTRL_W-1:0] ctrl;
		logic [15:0]       delay;
		logic [EV_W-1:0]   irq_stat;
		logic [EV_W-1:0]   irq_mask;
		logic              irq;
		logic              ack;
		logic [31:0]       rdata;
	} srdsc_regs_s;

	localparam srdsc_regs_s REGS_RST = '{state: ST_OFF, ctrl: CTRL_RST, delay: DELAY_RST,
		default: '0};

endpackage

// [core/srdsc_sync.sv]
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the levels are slow compared with the clock; no pulse stretching is done.
`timescale 1ns/1ps
module srdsc_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} srdsc_sync_s;

	srdsc_sync_s r;
	srdsc_sync_s next_r;

	always_comb begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.s2;
endmodule

// [core/srdsc_ctrl.sv]
// Delayed-stop safety relay controller with a Wishbone register file.
// Assumes all safety pins are asynchronous and that readback pins mirror the output drivers.
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ps
// Functional notes
// [RQ1] Manual start closes both groups only after start press then release with inputs closed.
// [RQ2] Opening the stop or door input drops the immediate group at once.
// [RQ3] After a stop the delayed group stays on for the selected delay, then drops.
// [RQ4] Start is ignored until the delayed group opens, unless the no-lockout variant is chosen.
// [RQ5] With the automatic start link present, outputs close once the safety inputs close.
// [RQ6] Dual channel compares both channels and blocks activation while a fault persists.
// [RQ7] Gate-lock variant energises both lock-release relays once the stop delay ends.
// [RQ8] Gate-lock variant: start first drops lock-release relays, then closes the main group.
// [RQ9] With activation delay chosen, outputs close about 100 ms after a valid release.
// [RQ10] Start monitoring checks press and release and closes 100 ms after release.
// [RQ11] Closed door switches without a release action leave all outputs off; the code keeps both lock-release relays on after a gate-lock stop delay.
// [RQ12] An open contactor feedback loop refuses activation.
// [RQ13] Installer wires every contactor NC auxiliary contact in series into the feedback loop.
// [RQ14] Output drivers are self-tested against their readback; mismatch latches a fault.
// [RQ15] Delay is a down-counter loaded at stop; the delayed group drops at zero.
module srdsc_ctrl #(
	parameter int MS_TICKS = srdsc_pkg::MS_CYCLES
) (
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [srdsc_pkg::ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic                        door_switch_one,
	input  wire logic                        door_switch_two,
	input  wire logic                        start_button,
	input  wire logic                        feedback_loop_in,
	input  wire logic                        auto_start_link,
	input  wire logic                        immediate_readback,
	input  wire logic                        delayed_readback,
	output logic                             immediate_out,
	output logic                             delayed_out,
	output logic                             lock_release_relay_a,
	output logic                             lock_release_relay_b,
	output logic                             irq
);
	if (MS_TICKS < 2 || MS_TICKS > 16777215) begin : g_chk
		$error("MS_TICKS must lie between 2 and 2**24-1");
	end

	localparam logic [23:0] MS_LAST = 24'(MS_TICKS - 1);

	srdsc_pkg::srdsc_regs_s r;
	srdsc_pkg::srdsc_regs_s next_r;
	srdsc_pkg::srdsc_pins_s pin_raw;
	srdsc_pkg::srdsc_pins_s s;

	assign pin_raw = '{door1: door_switch_one, door2: door_switch_two, start: start_button,
		fb: feedback_loop_in, auto_link: auto_start_link, imm_rb: immediate_readback,
		dly_rb: delayed_readback};

	srdsc_sync #(
		.W($bits(srdsc_pkg::srdsc_pins_s))
	) u_sync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.d       (pin_raw),
		.q       (s)
	);

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		return res;
	endfunction

	logic                       ms_tick, safe_ok, run_ok, press, release_ev, restart_ok, need_dly;
	logic                       mismatch, launch, enter_run, acc;
	logic [31:0]                wd, stat;
	logic [srdsc_pkg::EV_W-1:0] ev, clr;

	always_comb begin
		next_r     = r;
		ev         = '0;
		clr        = '0;
		launch     = 1'b0;
		enter_run  = 1'b0;
		wd         = '0;
		ms_tick    = (r.ms_cnt == MS_LAST);
		next_r.ms_cnt = ms_tick ? 24'h000000 : r.ms_cnt + 24'h000001;

		safe_ok    = r.ctrl[srdsc_pkg::CTRL_DUAL] ? (s.door1 & s.door2) : s.door1;
		run_ok     = safe_ok & ~r.ch_fault & ~r.st_fault;
		press      = s.start & ~r.start_q;
		release_ev = ~s.start & r.start_q;
		next_r.start_q = s.start;
		restart_ok = ~r.dly | r.ctrl[srdsc_pkg::CTRL_NOLOCK]; // [RQ4]
		need_dly   = r.ctrl[srdsc_pkg::CTRL_ACTDLY] | r.ctrl[srdsc_pkg::CTRL_STARTMON];

		// A start contact already closed when the inputs closed is not taken as a press.
		if (!run_ok) begin
			next_r.start_open = 1'b0;
		end else if (!s.start) begin
			next_r.start_open = 1'b1; // [RQ10]
		end

		// Channel discrepancy only latches after it has lasted, so contact bounce passes.
		if (r.ctrl[srdsc_pkg::CTRL_DUAL] && (s.door1 ^ s.door2)) begin
			if (ms_tick) begin
				next_r.disc_cnt = r.disc_cnt + 6'h01;
				if (r.disc_cnt == srdsc_pkg::DISC_LAST) begin
					next_r.ch_fault = 1'b1; // [RQ6]
					ev[srdsc_pkg::EV_CHF] = ~r.ch_fault;
				end
			end
		end else begin
			next_r.disc_cnt = '0;
			if (!s.door1 && !s.door2) begin
				next_r.ch_fault = 1'b0;
			end
		end

		mismatch = (s.imm_rb != r.imm) || (s.dly_rb != r.dly);
		if (mismatch) begin
			if (ms_tick) begin
				next_r.test_cnt = r.test_cnt + 5'h01;
				if (r.test_cnt == srdsc_pkg::TEST_LAST) begin
					next_r.st_fault = 1'b1; // [RQ14]
					ev[srdsc_pkg::EV_STF] = ~r.st_fault;
					next_r.test_cnt = '0;
				end
			end
		end else begin
			next_r.test_cnt = '0;
		end

		if (r.dly && r.state != srdsc_pkg::ST_ON && ms_tick) begin
			if (r.dly_cnt == 16'h0000) begin
				next_r.dly = 1'b0; // [RQ15]
				ev[srdsc_pkg::EV_DLYOF] = 1'b1;
				if (r.ctrl[srdsc_pkg::CTRL_GATELOCK]) begin
					next_r.lock = 1'b1; // [RQ7]
				end
			end else begin
				next_r.dly_cnt = r.dly_cnt - 16'h0001; // [RQ3]
			end
		end
		case (r.state)
			srdsc_pkg::ST_OFF: begin
				if (run_ok && s.fb && restart_ok) begin // [RQ12]
					if (s.auto_link) begin
						launch = 1'b1; // [RQ5]
					end else if (press && (r.start_open ||
						!r.ctrl[srdsc_pkg::CTRL_STARTMON])) begin
						next_r.state = srdsc_pkg::ST_ARMED; // [RQ11]
					end
				end
			end
			srdsc_pkg::ST_ARMED: begin
				if (!run_ok || !s.fb || !restart_ok) begin
					next_r.state = srdsc_pkg::ST_OFF;
				end else if (release_ev) begin
					launch = 1'b1; // [RQ1]
				end
			end
			srdsc_pkg::ST_RELOCK: begin
				// The loop is checked again here, since a contactor may weld while the locks drop.
				if (!run_ok || !s.fb) begin // [RQ12]
					next_r.state = srdsc_pkg::ST_OFF;
				end else if (ms_tick) begin
					enter_run = 1'b1; // [RQ8]
				end
			end
			srdsc_pkg::ST_ACT_WAIT: begin
				if (!run_ok || !s.fb) begin
					next_r.state = srdsc_pkg::ST_OFF;
				end else if (ms_tick) begin
					next_r.act_cnt = r.act_cnt + 7'h01;
					if (r.act_cnt == srdsc_pkg::ACT_LAST) begin
						next_r.state = srdsc_pkg::ST_ON; // [RQ9]
						next_r.imm   = 1'b1;
						next_r.dly   = 1'b1;
						ev[srdsc_pkg::EV_ACT] = 1'b1;
					end
				end
			end
			srdsc_pkg::ST_ON: begin
				if (!run_ok) begin
					next_r.state   = srdsc_pkg::ST_OFF;
					next_r.imm     = 1'b0; // [RQ2]
					next_r.dly_cnt = r.delay; // [RQ15]
					ev[srdsc_pkg::EV_STOP] = 1'b1;
				end
			end
			default: begin
				next_r.state = srdsc_pkg::ST_OFF;
				next_r.imm   = 1'b0;
			end
		endcase

		if (launch) begin
			if (r.ctrl[srdsc_pkg::CTRL_GATELOCK] && r.lock) begin
				next_r.lock  = 1'b0; // [RQ8]
				next_r.state = srdsc_pkg::ST_RELOCK;
			end else begin
				enter_run = 1'b1;
			end
		end
		if (enter_run) begin
			if (need_dly) begin
				next_r.state   = srdsc_pkg::ST_ACT_WAIT; // [RQ10]
				next_r.act_cnt = '0;
			end else begin
				next_r.state = srdsc_pkg::ST_ON;
				next_r.imm   = 1'b1;
				next_r.dly   = 1'b1;
				ev[srdsc_pkg::EV_ACT] = 1'b1;
			end
		end
		stat = '0;
		stat[srdsc_pkg::SB_IMM]  = r.imm;
		stat[srdsc_pkg::SB_DLY]  = r.dly;
		stat[srdsc_pkg::SB_LOCK] = r.lock;
		stat[srdsc_pkg::SB_CHF]  = r.ch_fault;
		stat[srdsc_pkg::SB_STF]  = r.st_fault;
		stat[srdsc_pkg::SB_SAFE] = safe_ok;
		stat[srdsc_pkg::SB_STATE +: $bits(srdsc_pkg::srdsc_state_e)] = r.state;
		acc        = wb_cyc_i & wb_stb_i & ~r.ack;
		next_r.ack = acc;
		if (acc && wb_we_i) begin
			case (wb_adr_i)
				srdsc_pkg::ADDR_CTRL: begin
					wd = wmerge(32'(r.ctrl), wb_dat_i, wb_sel_i);
					next_r.ctrl = wd[srdsc_pkg::CTRL_W-1:0];
					if (wd[srdsc_pkg::CTRL_FCLR] && !mismatch) begin
						next_r.st_fault = 1'b0;
					end
				end
				srdsc_pkg::ADDR_DLY: begin
					wd = wmerge(32'(r.delay), wb_dat_i, wb_sel_i);
					next_r.delay = wd[15:0];
				end
				srdsc_pkg::ADDR_IRQS: begin
					wd  = wmerge(32'h00000000, wb_dat_i, wb_sel_i);
					clr = wd[srdsc_pkg::EV_W-1:0];
				end
				srdsc_pkg::ADDR_IRQM: begin
					wd = wmerge(32'(r.irq_mask), wb_dat_i, wb_sel_i);
					next_r.irq_mask = wd[srdsc_pkg::EV_W-1:0];
				end
				default: begin
					wd = '0;
				end
			endcase
		end
		if (acc && !wb_we_i) begin
			case (wb_adr_i)
				srdsc_pkg::ADDR_CTRL: next_r.rdata = 32'(r.ctrl);
				srdsc_pkg::ADDR_DLY:  next_r.rdata = 32'(r.delay);
				srdsc_pkg::ADDR_STAT: next_r.rdata = stat;
				srdsc_pkg::ADDR_IRQS: next_r.rdata = 32'(r.irq_stat);
				srdsc_pkg::ADDR_IRQM: next_r.rdata = 32'(r.irq_mask);
				default:              next_r.rdata = 32'h00000000;
			endcase
		end
		// A new event wins over a clear written in the same cycle.
		next_r.irq_stat = (r.irq_stat & ~clr) | ev;
		next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			r <= srdsc_pkg::REGS_RST;
		end else begin
			r <= next_r;
		end
	end

	assign wb_dat_o             = r.rdata;
	assign wb_ack_o             = r.ack;
	assign immediate_out        = r.imm;
	assign delayed_out          = r.dly;
	assign lock_release_relay_a = r.lock;
	assign lock_release_relay_b = r.lock;
	assign irq                  = r.irq;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	stop_imm_off_a: assert property ( // [RQ2]
		r.state == srdsc_pkg::ST_ON && !run_ok |=> !r.imm && r.dly)
		else $error("immediate group did not drop on stop");
	stop_load_a: assert property ( // [RQ15]
		r.state == srdsc_pkg::ST_ON && !run_ok |=> r.dly_cnt == $past(r.delay))
		else $error("delay counter not loaded at stop");
	manual_need_a: assert property ( // [RQ1]
		r.state == srdsc_pkg::ST_OFF && !s.auto_link |=> !$rose(r.imm))
		else $error("outputs closed without start release");
	no_release_a: assert property ( // [RQ11]
		r.state == srdsc_pkg::ST_ARMED && s.start && !r.imm |=> !r.imm)
		else $error("outputs closed while start still pressed");
	restart_lock_a: assert property ( // [RQ4]
		r.state == srdsc_pkg::ST_OFF && r.dly && !r.ctrl[srdsc_pkg::CTRL_NOLOCK]
		|=> r.state == srdsc_pkg::ST_OFF)
		else $error("restart accepted during delay");
	auto_start_a: assert property ( // [RQ5]
		r.state == srdsc_pkg::ST_OFF && s.auto_link && run_ok && s.fb && !r.dly && !r.lock
		&& !need_dly ##1 !r.imm |-> 0)
		else $error("automatic start did not close outputs");
	ch_fault_a: assert property ( // [RQ6]
		r.ch_fault && !r.imm |=> !r.imm)
		else $error("outputs closed during channel fault");
	lock_delay_a: assert property ( // [RQ7]
		r.ctrl[srdsc_pkg::CTRL_GATELOCK] && r.dly && r.state == srdsc_pkg::ST_OFF && !run_ok
		&& r.dly_cnt == 16'h0000 && ms_tick |=> r.lock && !r.dly)
		else $error("lock release not energised after delay");
	relock_first_a: assert property ( // [RQ8]
		r.state == srdsc_pkg::ST_RELOCK |-> !r.lock && !r.imm)
		else $error("main group closed before lock relays dropped");
	act_hold_a: assert property ( // [RQ9]
		r.state == srdsc_pkg::ST_ACT_WAIT && r.act_cnt != srdsc_pkg::ACT_LAST |=> !r.imm)
		else $error("activation delay cut short");
	mon_release_a: assert property ( // [RQ10]
		r.state == srdsc_pkg::ST_ARMED && release_ev && run_ok && s.fb && restart_ok
		&& r.ctrl[srdsc_pkg::CTRL_STARTMON] && !r.ctrl[srdsc_pkg::CTRL_GATELOCK]
		|=> r.state == srdsc_pkg::ST_ACT_WAIT ##1 !r.imm)
		else $error("start release did not begin activation delay");
	fb_block_a: assert property ( // [RQ12]
		!s.fb && !r.imm && r.state != srdsc_pkg::ST_ACT_WAIT |=> !r.imm)
		else $error("activation with open feedback loop");
	self_test_a: assert property ( // [RQ14]
		mismatch && ms_tick && r.test_cnt == srdsc_pkg::TEST_LAST |=> r.st_fault)
		else $error("readback mismatch not latched");
endmodule

// [tb/srdsc_contactors.sv]
// Behavioural model of the external contactors driven by the relay outputs.
// Assumes one clock; readback and the feedback loop follow the coils one cycle late.
`timescale 1ns/1ps
module srdsc_contactors (
	input  wire logic mclk,
	input  wire logic imm_coil,
	input  wire logic dly_coil,
	input  wire logic weld,
	output logic      imm_rb,
	output logic      dly_rb,
	output logic      fb_loop
);
	initial imm_rb = 1'b0;
	initial dly_rb = 1'b0;
	// A welded contactor stays pulled in whatever its coil does.
	always @(posedge mclk) begin
		imm_rb <= imm_coil | weld;
		dly_rb <= dly_coil;
	end
	// Only the immediate group switches external contactors; their NC aux contacts
	// sit in series in the loop, so the delayed group never opens it.
	assign fb_loop = ~imm_rb;
endmodule

// [tb/tb.sv]
// Self-checking bench of the delayed-stop relay controller.
// Assumes the contactor model on the output side and a millisecond shortened to 4 cycles.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module tb;
	localparam int MT = 4;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        door_switch_one = 1'b1;
	logic        door_switch_two = 1'b1;
	logic        start_button = 1'b0;
	logic        auto_start_link = 1'b0;
	logic        weld = 1'b0;
	logic        fb;
	logic        rb_imm;
	logic        rb_dly;
	logic        immediate_out;
	logic        delayed_out;
	logic        lock_release_relay_a;
	logic        lock_release_relay_b;
	logic        irq;
	logic [4:0]  outs;
	logic        probe = 1'b0;
	logic [3:0]  ev4;
	logic [31:0] ev32;
	logic [3:0]  pin_q [$];
	logic [31:0] rd_q [$];
	logic [31:0] md [2] = '{32'h2, 32'h4};
	int          err_count = 0;
	int          n_checks = 0;
	int          dly_ms;

	assign outs = {irq, lock_release_relay_b, lock_release_relay_a, delayed_out, immediate_out};
	initial forever #25 mclk = ~mclk;

	srdsc_ctrl #(.MS_TICKS(MT)) dut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.door_switch_one(door_switch_one), .door_switch_two(door_switch_two),
		.start_button(start_button), .feedback_loop_in(fb), .auto_start_link(auto_start_link),
		.immediate_readback(rb_imm), .delayed_readback(rb_dly), .immediate_out(immediate_out),
		.delayed_out(delayed_out), .lock_release_relay_a(lock_release_relay_a),
		.lock_release_relay_b(lock_release_relay_b), .irq(irq));
	srdsc_contactors model (.mclk(mclk), .imm_coil(immediate_out), .dly_coil(delayed_out),
		.weld(weld), .imm_rb(rb_imm), .dly_rb(rb_dly), .fb_loop(fb));

	// Results are compared in the sampling edge, before the release of the request lands.
	always @(posedge mclk) begin
		if (probe) begin
			ev4 = pin_q.pop_front();
			`CHK(outs[3:0], ev4)
		end
		if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
			ev32 = rd_q.pop_front();
			`CHK(wb_dat_o, ev32)
		end
	end

	task automatic conclude();
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (k = 0; k < 20; k++) begin
			@(posedge mclk);
			if (wb_ack_o === 1'b1) break;
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		`CHK(1'(k < 20), 1'b1)
		if (k == 20) conclude();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	// Waits a bounded number of edges for one output to reach a level.
	task automatic wait_out(input int i, input logic v, input int lim);
		int k;
		for (k = 0; k < lim; k++) begin
			@(posedge mclk);
			if (outs[i] === v) break;
		end
		`CHK(1'(k < lim), 1'b1)
		if (k == lim) conclude();
	endtask

	task automatic pins(input logic [3:0] e);
		@(posedge mclk);
		pin_q.push_back(e);
		probe <= 1'b1;
		@(posedge mclk);
		probe <= 1'b0;
	endtask

	task automatic doors(input logic v);
		door_switch_one <= v;
		door_switch_two <= v;
	endtask

	task automatic tap();
		start_button <= 1'b1;
		repeat (8) @(posedge mclk);
		start_button <= 1'b0;
	endtask

	task automatic stop_wait();
		doors(1'b0);
		wait_out(0, 1'b0, 6);
		wait_out(1, 1'b0, (dly_ms + 3) * MT);
		doors(1'b1);
		repeat (10) @(posedge mclk);
	endtask

	initial begin
		void'($urandom(32'h21AEEECD));
		dly_ms = 6 + $urandom % 8;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		pins(4'h0);
		rd(8'h00, 32'h3);
		rd(8'h04, 32'h3E8);
		rd(8'h14, 32'h0);
		wr(8'h04, 32'(dly_ms));
		rd(8'h04, 32'(dly_ms));
		wr(8'h00, 32'h0);
		start_button <= 1'b1;
		repeat (12) @(posedge mclk);
		pins(4'h0);
		start_button <= 1'b0;
		wait_out(0, 1'b1, 8);
		pins(4'h3);
		rd(8'h08, 32'h423);
		// A mask bit set to one lets its status bit through to the interrupt line.
		wr(8'h10, 32'h1F);
		wait_out(4, 1'b1, 4);
		rd(8'h0C, 32'h1);
		wr(8'h10, 32'h0);
		wait_out(4, 1'b0, 4);
		wr(8'h10, 32'h1F);
		wait_out(4, 1'b1, 4);
		wr(8'h0C, 32'h1F);
		wait_out(4, 1'b0, 4);
		rd(8'h0C, 32'h0);
		doors(1'b0);
		wait_out(0, 1'b0, 4);
		doors(1'b1);
		tap();
		repeat (dly_ms * MT - 16) @(posedge mclk);
		pins(4'h2);
		wait_out(1, 1'b0, 20);
		pins(4'h0);
		tap();
		wait_out(0, 1'b1, 8);
		wr(8'h00, 32'h8);
		doors(1'b0);
		wait_out(0, 1'b0, 4);
		doors(1'b1);
		tap();
		wait_out(0, 1'b1, 8);
		pins(4'h3);
		stop_wait();
		wr(8'h00, 32'h0);
		doors(1'b0);
		auto_start_link <= 1'b1;
		repeat (20) @(posedge mclk);
		doors(1'b1);
		wait_out(0, 1'b1, 8);
		auto_start_link <= 1'b0;
		stop_wait();
		// Both the plain activation delay and start monitoring hold off for 100 ms.
		foreach (md[i]) begin
			wr(8'h00, md[i]);
			tap();
			repeat (360) @(posedge mclk);
			pins(4'h0);
			wait_out(0, 1'b1, 80);
			stop_wait();
		end
		wr(8'h00, 32'h1);
		wr(8'h0C, 32'h1F);
		door_switch_two <= 1'b0;
		repeat (260) @(posedge mclk);
		rd(8'h0C, 32'h8);
		door_switch_two <= 1'b1;
		tap();
		repeat (20) @(posedge mclk);
		pins(4'h0);
		doors(1'b0);
		repeat (20) @(posedge mclk);
		doors(1'b1);
		repeat (20) @(posedge mclk);
		tap();
		wait_out(0, 1'b1, 8);
		stop_wait();
		wr(8'h00, 32'h10);
		tap();
		wait_out(0, 1'b1, 8);
		doors(1'b0);
		wait_out(0, 1'b0, 4);
		wait_out(2, 1'b1, (dly_ms + 3) * MT);
		pins(4'hC);
		doors(1'b1);
		tap();
		wait_out(2, 1'b0, 10);
		wait_out(0, 1'b1, 16);
		pins(4'h3);
		stop_wait();
		wr(8'h0C, 32'h1F);
		weld <= 1'b1;
		repeat (10) @(posedge mclk);
		tap();
		repeat (20) @(posedge mclk);
		`CHK(outs[1:0], 2'h0)
		repeat (100) @(posedge mclk);
		rd(8'h0C, 32'h10);
		// Once the readback agrees again, the fault clear bit must drop the self-test fault.
		weld <= 1'b0;
		repeat (10) @(posedge mclk);
		wr(8'h00, 32'h30);
		rd(8'h08, 32'h24);
		repeat (4) @(posedge mclk);
		conclude();
	end
endmodule
